// *** logic/xfc_ctrl.sv ***
// Transfer controller: enable bank, activation routing and transfer engine.
//
// The Wishbone register port and the address map are this design's own decisions.
`include "xfc_consts.svh"

module xfc_ctrl
  import xfc_pkg::*;
#(
  parameter int NUM_BANKS = 7,
  parameter int NUM_SRC = 8 * NUM_BANKS,
  parameter int IDX_W = $clog2(NUM_SRC)
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] src_flag_i,
  output logic [NUM_SRC-1:0] cpu_req_o,
  output logic [NUM_SRC-1:0] flag_clr_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [1:0] mem_size_o,
  output logic [23:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic busy_o
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [NUM_SRC-1:0] en_reg;
  logic [23:0] info_base_reg;
  logic [NUM_SRC-1:0] act_req;
  logic pick_any;
  logic [IDX_W-1:0] pick_idx;
  xfc_state_t state_reg;
  logic [IDX_W-1:0] idx_reg;
  logic [23:0] set_addr_reg;
  logic [1:0] wcnt_reg;
  logic [7:0] mwa_reg;
  logic [7:0] mwb_reg;
  logic [23:0] src_ptr_reg;
  logic [23:0] dst_ptr_reg;
  logic [15:0] cnt_a_reg;
  logic [15:0] cnt_b_reg;
  logic [15:0] data_reg;
  logic ended_reg;
  logic cnt_zero_reg;
  logic last_ended_reg;
  xfc_mode_t xfer_mode;
  logic unit_size;
  logic area_side;
  logic [15:0] cnt_a_next;
  logic [15:0] cnt_b_next;
  logic [7:0] inner_next;
  logic wrap;
  logic cnt_zero;
  logic ended;
  logic blk_more;
  logic [23:0] src_ptr_next;
  logic [23:0] dst_ptr_next;
  logic chain_go;
  logic end_clear;
  logic mem_state;
  logic mem_done;
  logic mem_we_next;
  logic [1:0] mem_size_next;
  logic [23:0] mem_addr_next;
  logic [31:0] mem_wdata_next;
  logic wb_write;
  logic [31:0] wb_rdata;

  function automatic logic addr_hit(input logic [7:0] adr,
                                    input logic [7:0] ofs);
    addr_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // --------------------------------------------------------------------------
  // Register bus slave
  // --------------------------------------------------------------------------
  // Writes land on the edge where the master samples ack high.
  assign wb_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= wb_rdata;
    end
  end

  // Unmapped offsets read as zero and ignore writes.
  always_comb
  begin
    wb_rdata = 32'h00000000;
    for (int k = 0; k < NUM_BANKS; k++)
    begin
      if (addr_hit(wb_adr_i, `XFC_OFS_EN_BASE + 8'(4 * k)))
        wb_rdata = {24'h000000, en_reg[8*k +: 8]};
    end
    if (addr_hit(wb_adr_i, `XFC_OFS_INFO_BASE))
      wb_rdata = {8'h00, info_base_reg};
    if (addr_hit(wb_adr_i, `XFC_OFS_STATUS))
    begin
      wb_rdata[`XFC_STAT_BUSY] = busy_o;
      wb_rdata[`XFC_STAT_ENDED] = last_ended_reg;
      wb_rdata[IDX_W-1:0] = idx_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      info_base_reg <= `XFC_INFO_BASE_RESET;
    else if (wb_write && addr_hit(wb_adr_i, `XFC_OFS_INFO_BASE))
    begin
      if (wb_sel_i[0])
        info_base_reg[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        info_base_reg[15:8] <= wb_dat_i[15:8];
      if (wb_sel_i[2])
        info_base_reg[23:16] <= wb_dat_i[23:16];
    end
  end

  // --------------------------------------------------------------------------
  // Activation enable bank
  // --------------------------------------------------------------------------
  // A software write in the same cycle as a hardware clear wins, so a
  // freshly armed source is never lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      en_reg <= {NUM_BANKS{`XFC_EN_RESET}};
    else
    begin
      if (state_reg == XFC_FIN && !chain_go && end_clear)
        en_reg[idx_reg] <= 1'b0;
      for (int k = 0; k < NUM_BANKS; k++)
      begin
        if (wb_write && wb_sel_i[0]
            && addr_hit(wb_adr_i, `XFC_OFS_EN_BASE + 8'(4 * k)))
          en_reg[8*k +: 8] <= wb_dat_i[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Source routing
  // --------------------------------------------------------------------------
  // Once the enable is cleared, the still-set source flag reaches the CPU.
  assign act_req = src_flag_i & en_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_req_o <= '0;
      flag_clr_o <= '0;
    end
    else
    begin
      cpu_req_o <= src_flag_i & ~en_reg;
      flag_clr_o <= '0;
      if (state_reg == XFC_FIN && !chain_go && !end_clear)
        flag_clr_o[idx_reg] <= 1'b1;
    end
  end

  xfc_pick #(
    .N(NUM_SRC),
    .IDX_W(IDX_W)
  ) u_pick (
    .req_i(act_req),
    .any_o(pick_any),
    .idx_o(pick_idx)
  );

  // --------------------------------------------------------------------------
  // Counters and pointers
  // --------------------------------------------------------------------------
  assign xfer_mode = xfc_mode_t'(mwa_reg[`XFC_MWA_XFER_MODE]);
  assign unit_size = mwa_reg[`XFC_MWA_UNIT_SIZE];
  assign area_side = mwa_reg[`XFC_MWA_AREA_SIDE];
  assign inner_next = cnt_a_reg[7:0] - 8'h01;

  // The prohibited mode code behaves as normal mode.
  always_comb
  begin
    cnt_a_next = cnt_a_reg - 16'h0001;
    cnt_b_next = cnt_b_reg;
    wrap = 1'b0;
    blk_more = 1'b0;
    cnt_zero = (cnt_a_next == 16'h0000);
    ended = cnt_zero;
    case (xfer_mode)
      XFC_REPEAT:
      begin
        wrap = (inner_next == 8'h00);
        cnt_a_next = {cnt_a_reg[15:8], wrap ? cnt_a_reg[15:8] : inner_next};
        cnt_zero = wrap;
        ended = 1'b0;
      end
      XFC_BLOCK:
      begin
        wrap = (inner_next == 8'h00);
        cnt_a_next = {cnt_a_reg[15:8], wrap ? cnt_a_reg[15:8] : inner_next};
        cnt_b_next = wrap ? cnt_b_reg - 16'h0001 : cnt_b_reg;
        cnt_zero = wrap && (cnt_b_next == 16'h0000);
        ended = cnt_zero;
        blk_more = !wrap;
      end
      default:
      begin
        cnt_zero = (cnt_a_next == 16'h0000);
      end
    endcase
  end

  // The repeat or block area returns to its start when the inner count wraps.
  xfc_ptr_step u_src_step (
    .ptr_i(src_ptr_reg),
    .mode_i(mwa_reg[`XFC_MWA_SRC_MODE]),
    .size_i(unit_size),
    .restore_i(wrap & area_side),
    .reload_i(cnt_a_reg[15:8]),
    .ptr_o(src_ptr_next)
  );

  xfc_ptr_step u_dst_step (
    .ptr_i(dst_ptr_reg),
    .mode_i(mwa_reg[`XFC_MWA_DST_MODE]),
    .size_i(unit_size),
    .restore_i(wrap & ~area_side),
    .reload_i(cnt_a_reg[15:8]),
    .ptr_o(dst_ptr_next)
  );

  // Mode word B bits 4 to 0 feed only the write-back of the mode word.
  assign chain_go = mwb_reg[`XFC_MWB_LINK_NEXT]
    && (!mwb_reg[`XFC_MWB_LINK_COND] || cnt_zero_reg);
  assign end_clear = mwb_reg[`XFC_MWB_IRQ_EVERY] || ended_reg;

  // --------------------------------------------------------------------------
  // Memory port
  // --------------------------------------------------------------------------
  assign mem_state = (state_reg == XFC_FETCH) || (state_reg == XFC_SRC)
    || (state_reg == XFC_DST) || (state_reg == XFC_BACK);
  assign mem_done = mem_req_o & mem_ack_i;

  always_comb
  begin
    mem_we_next = 1'b0;
    mem_size_next = `XFC_SIZE_INFO;
    mem_addr_next = set_addr_reg + {20'h00000, wcnt_reg, 2'h0};
    mem_wdata_next = 32'h00000000;
    case (state_reg)
      XFC_SRC:
      begin
        mem_size_next = {1'b0, unit_size};
        mem_addr_next = src_ptr_reg;
      end
      XFC_DST:
      begin
        mem_we_next = 1'b1;
        mem_size_next = {1'b0, unit_size};
        mem_addr_next = dst_ptr_reg;
        mem_wdata_next = {16'h0000, data_reg};
      end
      XFC_BACK:
      begin
        mem_we_next = 1'b1;
        case (wcnt_reg)
          2'h0: mem_wdata_next = {mwa_reg, src_ptr_reg};
          2'h1: mem_wdata_next = {mwb_reg, dst_ptr_reg};
          default: mem_wdata_next = {cnt_a_reg, cnt_b_reg};
        endcase
      end
      default:
      begin
        mem_we_next = 1'b0;
      end
    endcase
  end

  // The request drops for at least one cycle after each ack before the next one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_size_o <= 2'h0;
      mem_addr_o <= 24'h000000;
      mem_wdata_o <= 32'h00000000;
    end
    else if (mem_done)
      mem_req_o <= 1'b0;
    else if (mem_state && !mem_req_o)
    begin
      mem_req_o <= 1'b1;
      mem_we_o <= mem_we_next;
      mem_size_o <= mem_size_next;
      mem_addr_o <= mem_addr_next;
      mem_wdata_o <= mem_wdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= XFC_IDLE;
      idx_reg <= '0;
      set_addr_reg <= 24'h000000;
      wcnt_reg <= 2'h0;
      mwa_reg <= 8'h00;
      mwb_reg <= 8'h00;
      src_ptr_reg <= 24'h000000;
      dst_ptr_reg <= 24'h000000;
      cnt_a_reg <= 16'h0000;
      cnt_b_reg <= 16'h0000;
      data_reg <= 16'h0000;
      ended_reg <= 1'b0;
      cnt_zero_reg <= 1'b0;
      last_ended_reg <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (state_reg != XFC_IDLE) || pick_any;
      case (state_reg)
        XFC_IDLE:
        begin
          if (pick_any)
          begin
            idx_reg <= pick_idx;
            set_addr_reg <= info_base_reg
              + (24'(pick_idx) << `XFC_SLOT_SHIFT);
            wcnt_reg <= 2'h0;
            state_reg <= XFC_FETCH;
          end
        end
        XFC_FETCH:
        begin
          if (mem_done)
          begin
            case (wcnt_reg)
              2'h0: {mwa_reg, src_ptr_reg} <= mem_rdata_i;
              2'h1: {mwb_reg, dst_ptr_reg} <= mem_rdata_i;
              default: {cnt_a_reg, cnt_b_reg} <= mem_rdata_i;
            endcase
            if (wcnt_reg == `XFC_LAST_WORD)
              state_reg <= XFC_SRC;
            else
              wcnt_reg <= wcnt_reg + 2'h1;
          end
        end
        XFC_SRC:
        begin
          if (mem_done)
          begin
            data_reg <= unit_size ? mem_rdata_i[15:0]
                                  : {8'h00, mem_rdata_i[7:0]};
            state_reg <= XFC_DST;
          end
        end
        XFC_DST:
        begin
          if (mem_done)
            state_reg <= XFC_UPD;
        end
        XFC_UPD:
        begin
          src_ptr_reg <= src_ptr_next;
          dst_ptr_reg <= dst_ptr_next;
          cnt_a_reg <= cnt_a_next;
          cnt_b_reg <= cnt_b_next;
          ended_reg <= ended;
          cnt_zero_reg <= cnt_zero;
          wcnt_reg <= 2'h0;
          state_reg <= blk_more ? XFC_SRC : XFC_BACK;
        end
        XFC_BACK:
        begin
          if (mem_done)
          begin
            if (wcnt_reg == `XFC_LAST_WORD)
              state_reg <= XFC_FIN;
            else
              wcnt_reg <= wcnt_reg + 2'h1;
          end
        end
        XFC_FIN:
        begin
          if (chain_go)
          begin
            // No end check and no clearing on a linked set.
            set_addr_reg <= set_addr_reg + `XFC_SET_BYTES;
            wcnt_reg <= 2'h0;
            state_reg <= XFC_FETCH;
          end
          else
          begin
            last_ended_reg <= ended_reg;
            state_reg <= XFC_GAP;
          end
        end
        XFC_GAP:
        begin
          // Gives the source time to drop its flag before the next pick.
          state_reg <= XFC_IDLE;
        end
        default:
        begin
          state_reg <= XFC_IDLE;
        end
      endcase
    end
  end

endmodule

// *** common/xfc_consts.svh ***
// Register offsets, field positions and reset values of the transfer controller.
`ifndef XFC_CONSTS_SVH
`define XFC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Bus register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define XFC_OFS_EN_BASE 8'h00
`define XFC_OFS_INFO_BASE 8'h1C
`define XFC_OFS_STATUS 8'h20

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define XFC_EN_RESET 8'h00
`define XFC_INFO_BASE_RESET 24'h000000

// ----------------------------------------------------------------------------
// Register information layout in memory
// ----------------------------------------------------------------------------
`define XFC_SET_BYTES 24'h00000C
`define XFC_SLOT_SHIFT 6
`define XFC_LAST_WORD 2'h2
`define XFC_SIZE_INFO 2'h2

// ----------------------------------------------------------------------------
// Field positions of the mode words and the status register
// ----------------------------------------------------------------------------
`define XFC_MWB_LINK_NEXT 7
`define XFC_MWB_IRQ_EVERY 6
`define XFC_MWB_LINK_COND 5
`define XFC_MWA_SRC_MODE 7:6
`define XFC_MWA_DST_MODE 5:4
`define XFC_MWA_XFER_MODE 3:2
`define XFC_MWA_AREA_SIDE 1
`define XFC_MWA_UNIT_SIZE 0
`define XFC_STAT_BUSY 31
`define XFC_STAT_ENDED 30

`endif

// *** common/xfc_pkg.sv ***
// Types shared by the transfer controller modules.
package xfc_pkg;

  typedef enum logic [7:0] {
    XFC_IDLE  = 8'h01,
    XFC_FETCH = 8'h02,
    XFC_SRC   = 8'h04,
    XFC_DST   = 8'h08,
    XFC_UPD   = 8'h10,
    XFC_BACK  = 8'h20,
    XFC_FIN   = 8'h40,
    XFC_GAP   = 8'h80
  } xfc_state_t;

  typedef enum logic [1:0] {
    XFC_NORMAL = 2'h0,
    XFC_REPEAT = 2'h1,
    XFC_BLOCK  = 2'h2,
    XFC_BAD    = 2'h3
  } xfc_mode_t;

endpackage

// *** logic/xfc_pick.sv ***
// Fixed-priority picker of pending activation requests.
module xfc_pick #(
  parameter int N = 56,
  parameter int IDX_W = 6
)
(
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [IDX_W-1:0] idx_o
);

  // The lowest index wins, so the scan runs downward.
  always_comb
  begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req_i[i])
      begin
        any_o = 1'b1;
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule

// *** logic/xfc_ptr_step.sv ***
// Next value of one 24-bit pointer after a data unit.
module xfc_ptr_step (
  input wire logic [23:0] ptr_i,
  input wire logic [1:0] mode_i,
  input wire logic size_i,
  input wire logic restore_i,
  input wire logic [7:0] reload_i,
  output logic [23:0] ptr_o
);

  logic [23:0] step;
  logic [23:0] span;

  // A restore walks the pointer back over the whole area it just swept.
  always_comb
  begin
    step = size_i ? 24'h000002 : 24'h000001;
    span = {15'h0000, (reload_i == 8'h00), reload_i} << size_i;
    ptr_o = ptr_i;
    if (mode_i[1])
    begin
      if (!mode_i[0])
        ptr_o = ptr_i + step - (restore_i ? span : 24'h000000);
      else
        ptr_o = ptr_i - step + (restore_i ? span : 24'h000000);
    end
  end

endmodule

// *** tb/xfc_ctrl_monitor.sv ***
// Checker of the transfer controller's bus, memory and source ports.
module xfc_ctrl_monitor #(
  parameter int NUM_SRC = 56
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [NUM_SRC-1:0] src_flag_i,
  input wire logic [NUM_SRC-1:0] cpu_req_o,
  input wire logic [NUM_SRC-1:0] flag_clr_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [1:0] mem_size_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_mem_wait;
    mem_req_o && !mem_ack_i;
  endsequence
  property p_wb_ack;
    s_wb_req |=> wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus request not acknowledged");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack longer than one cycle");
  property p_cpu_route;
    (cpu_req_o & ~$past(src_flag_i)) == '0;
  endproperty
  a_cpu_route: assert property (p_cpu_route)
    else $error("cpu request without source flag");
  property p_clr_pulse;
    |flag_clr_o |-> $onehot(flag_clr_o) ##1 !(|flag_clr_o);
  endproperty
  a_clr_pulse: assert property (p_clr_pulse)
    else $error("flag clear not a single pulse");
  property p_clr_keep;
    |flag_clr_o |=> (cpu_req_o & $past(flag_clr_o)) == '0;
  endproperty
  a_clr_keep: assert property (p_clr_keep)
    else $error("served source reached the cpu");
  property p_mem_hold;
    s_mem_wait |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)
      && $stable(mem_size_o) && $stable(mem_wdata_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed before ack");
  property p_mem_drop;
    mem_req_o && mem_ack_i |=> !mem_req_o;
  endproperty
  a_mem_drop: assert property (p_mem_drop)
    else $error("memory request held after ack");
  property p_busy;
    mem_req_o || |flag_clr_o |-> busy_o;
  endproperty
  a_busy: assert property (p_busy)
    else $error("engine active while not busy");
  property p_size;
    mem_req_o |-> mem_size_o != 2'h3;
  endproperty
  a_size: assert property (p_size)
    else $error("illegal memory size code");
endmodule

bind xfc_ctrl xfc_ctrl_monitor #(.NUM_SRC(NUM_SRC)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .src_flag_i(src_flag_i), .cpu_req_o(cpu_req_o),
  .flag_clr_o(flag_clr_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_size_o(mem_size_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o));

// *** tb/xfc_mem_model.sv ***
// Behavioural system memory answering the controller's memory port.
module xfc_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] size_i,
  input wire logic [23:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] m [0:1023];
  logic [31:0] mask;
  logic [1:0] wait_cnt;
  assign mask = size_i == 2'h0 ? 32'h000000FF :
                size_i == 2'h1 ? 32'h0000FFFF : 32'hFFFFFFFF;
  // Read data toggles after each ack and while no request is pending, and holds during slow wait cycles, so a stale value is never trusted.
  always @(posedge clk_i)
  begin
    if (rst_i || ack_o || !req_i)
    begin
      ack_o <= 1'b0;
      wait_cnt <= 2'h0;
      rdata_o <= rst_i ? 32'h0 : ~rdata_o;
    end
    else if (slow_i && wait_cnt != 2'h3)
      wait_cnt <= wait_cnt + 2'h1;
    else
    begin
      ack_o <= 1'b1;
      rdata_o <= m[addr_i[9:0]] & mask;
      if (we_i)
        m[addr_i[9:0]] <= (m[addr_i[9:0]] & ~mask) | (wdata_i & mask);
    end
  end
endmodule

// *** tb/data_transfer_ctrl_regs_tb_top.sv ***
// Self-checking testbench of the transfer controller.
`include "xfc_consts.svh"
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))
module data_transfer_ctrl_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slow = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [55:0] flag = '0;
  logic [31:0] rdat, mwd, mrd;
  logic [55:0] cpu, clr;
  logic ack, mreq, mwe, mack, busy;
  logic [1:0] msz;
  logic [23:0] maddr;
  int failures = 0;
  int n_tests = 0;

  always #12.5 clk = ~clk;

  xfc_ctrl u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .src_flag_i(flag), .cpu_req_o(cpu),
    .flag_clr_o(clr), .mem_req_o(mreq), .mem_we_o(mwe), .mem_size_o(msz),
    .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_rdata_i(mrd),
    .mem_ack_i(mack), .busy_o(busy));
  xfc_mem_model u_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .req_i(mreq), .we_i(mwe), .size_i(msz), .addr_i(maddr), .wdata_i(mwd),
    .rdata_o(mrd), .ack_o(mack));

  task automatic chk(string n, logic [31:0] e, logic [31:0] a);
    n_tests++;
    if (a !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, a);
    end
  endtask

  // The request is held until ack; only the watchdog bounds the wait.
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    `CHK("ack drop", 1'b0, ack);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  task automatic info(int b, logic [31:0] w0, logic [31:0] w1,
                      logic [31:0] w2);
    u_mem.m[b] = w0;
    u_mem.m[b + 4] = w1;
    u_mem.m[b + 8] = w2;
  endtask

  // Raise one source flag and drop it once the engine clears or rejects it.
  task automatic act(int i, output logic c, output logic p);
    int k;
    c = 1'b0;
    p = 1'b0;
    @(posedge clk);
    flag[i] <= 1'b1;
    for (k = 0; k < 2000 && !c && !p; k++)
    begin
      @(posedge clk);
      c = clr[i];
      p = cpu[i];
    end
    flag[i] <= 1'b0;
    for (k = 0; k < 50 && busy !== 1'b0; k++)
      @(posedge clk);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    for (int k = 0; k < 7; k++)
    begin
      rd(`XFC_OFS_EN_BASE + 8'(4 * k), q);
      `CHK("bank reset", 8'h00, q);
    end
    wr(8'h3C, 32'hFFFFFFFF);
    rd(8'h3C, q);
    `CHK("unmapped", 32'h0, q);
    wr(8'h18, 32'hA5);
    rd(8'h18, q);
    `CHK("bank 6", 32'hA5, q);
    wr(8'h18, 32'h0);
    wr(`XFC_OFS_INFO_BASE, 32'hFF123456);
    rd(`XFC_OFS_INFO_BASE, q);
    `CHK("info base", 32'h00123456, q);
    wr(`XFC_OFS_INFO_BASE, 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_normal;
    logic [31:0] q;
    logic c, p;
    info(0, {8'hA0, 24'h000300}, {8'h00, 24'h000310}, 32'h0002_1234);
    u_mem.m[10'h300] = 32'h5A;
    u_mem.m[10'h301] = 32'hC3;
    wr(8'h00, 32'h01);
    act(0, c, p);
    `CHK("clr first", 1'b1, c);
    `CHK("cpu first", 1'b0, p);
    `CHK("dst byte", 8'h5A, u_mem.m[10'h310][7:0]);
    `CHK("src back", {8'hA0, 24'h000301}, u_mem.m[0]);
    `CHK("dst back", {8'h00, 24'h000311}, u_mem.m[4]);
    `CHK("count", 32'h0001_1234, u_mem.m[8]);
    rd(8'h00, q);
    `CHK("bank kept", 8'h01, q);
    act(0, c, p);
    `CHK("cpu last", 1'b1, p);
    `CHK("dst byte 2", 8'hC3, u_mem.m[10'h311][7:0]);
    `CHK("count end", 32'h0000_1234, u_mem.m[8]);
    rd(`XFC_OFS_STATUS, q);
    `CHK("status end", 32'h4000_0000, q);
    rd(8'h00, q);
    `CHK("bank clear", 8'h00, q);
    $display("t_normal done");
  endtask

  task automatic t_every;
    logic [31:0] q;
    logic c, p;
    slow <= 1'b1;
    // Even pointers for a word unit; reserved mode bits deliberately set.
    info(10'h040, {8'h01, 24'h000320}, {8'h5F, 24'h000330},
      32'h0005_0000);
    u_mem.m[10'h320] = 32'hBEEF;
    wr(8'h00, 32'h02);
    act(1, c, p);
    slow <= 1'b0;
    `CHK("cpu every", 1'b1, p);
    `CHK("dst word", 16'hBEEF, u_mem.m[10'h330][15:0]);
    `CHK("count", 32'h0004_0000, u_mem.m[10'h048]);
    rd(8'h00, q);
    `CHK("bank clear", 8'h00, q);
    $display("t_every done");
  endtask

  task automatic t_chain;
    logic [31:0] q;
    logic c, p;
    info(10'h080, {8'h80, 24'h000340}, {8'h80, 24'h000350}, 32'h0001_0000);
    info(10'h08C, {8'h00, 24'h000341}, {8'h00, 24'h000351}, 32'h0003_0000);
    u_mem.m[10'h340] = 32'h11;
    u_mem.m[10'h341] = 32'h22;
    wr(8'h00, 32'h04);
    act(2, c, p);
    `CHK("clr chain", 1'b1, c);
    `CHK("first dst", 8'h11, u_mem.m[10'h350][7:0]);
    `CHK("next dst", 8'h22, u_mem.m[10'h351][7:0]);
    `CHK("first count", 32'h0, u_mem.m[10'h088]);
    `CHK("next count", 32'h0002_0000, u_mem.m[10'h094]);
    rd(8'h00, q);
    `CHK("bank kept", 8'h04, q);
    u_mem.m[10'h084] = {8'hA0, 24'h000350};
    u_mem.m[10'h088] = 32'h0003_0000;
    act(2, c, p);
    `CHK("clr cond", 1'b1, c);
    `CHK("no chain", 32'h0002_0000, u_mem.m[10'h094]);
    `CHK("cond count", 32'h0002_0000, u_mem.m[10'h088]);
    $display("t_chain done");
  endtask

  task automatic t_block;
    logic [31:0] q;
    logic c, p;
    info(10'h0C0, {8'hA8, 24'h000360}, {8'h00, 24'h000370}, 32'h0202_0003);
    u_mem.m[10'h360] = 32'h01;
    u_mem.m[10'h361] = 32'h02;
    rd(8'h00, q);
    wr(8'h00, q | 32'h08);
    act(3, c, p);
    `CHK("clr block", 1'b1, c);
    `CHK("unit 0", 8'h01, u_mem.m[10'h370][7:0]);
    `CHK("unit 1", 8'h02, u_mem.m[10'h371][7:0]);
    `CHK("src back", {8'hA8, 24'h000362}, u_mem.m[10'h0C0]);
    `CHK("dst restore", 32'h000370, u_mem.m[10'h0C4]);
    `CHK("counts", 32'h0202_0002, u_mem.m[10'h0C8]);
    rd(`XFC_OFS_STATUS, q);
    `CHK("status", 32'h0000_0003, q);
    $display("t_block done");
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    final_report();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_normal();
    t_every();
    t_chain();
    t_block();
    final_report();
  end
endmodule
